// >>> common/bst_pkg.sv
`default_nettype none

package bst_pkg;

  localparam int BST_INS_WIDTH = 4;
  localparam logic [3:0] BST_INS_CAPTURE = 4'h9;
  localparam logic [3:0] BST_INS_RESET = 4'h9;
  localparam logic [3:0] BST_OP_EXTEST = 4'h0;
  localparam logic [3:0] BST_OP_SAMPLE = 4'h4;

  localparam int BST_IN_CELLS = 8;
  localparam int BST_VIDEO_WIDTH = 16;
  localparam int BST_CHAIN_LEN = BST_IN_CELLS + BST_VIDEO_WIDTH + 1;
  localparam int BST_DRIVE_LEN = BST_VIDEO_WIDTH + 1;

  localparam logic BST_BYPASS_CAPTURE = 1'b0;

  typedef enum logic [3:0] {
    BST_TLR,
    BST_IDLE,
    BST_SEL_DR,
    BST_CAP_DR,
    BST_SHF_DR,
    BST_EX1_DR,
    BST_PAU_DR,
    BST_EX2_DR,
    BST_UPD_DR,
    BST_SEL_INS,
    BST_CAP_INS,
    BST_SHF_INS,
    BST_EX1_INS,
    BST_PAU_INS,
    BST_EX2_INS,
    BST_UPD_INS
  } bst_tap_state_t;

  // Low bits sit nearest the scan data input
  typedef struct packed {
    logic videoEn;
    logic [BST_VIDEO_WIDTH-1:0] video;
    logic [BST_IN_CELLS-1:0] inputs;
  } bst_cells_t;

  typedef struct packed {
    logic videoEn;
    logic [BST_VIDEO_WIDTH-1:0] video;
  } bst_drive_t;

endpackage

`default_nettype wire

// >>> rtl/bst_update_stage.sv
`default_nettype none

// Falling-edge half of the scan logic
module bst_update_stage (
  input wire logic scanClk,
  input wire logic scanRst,
  input wire bst_pkg::bst_tap_state_t tapState,
  input wire logic [bst_pkg::BST_INS_WIDTH-1:0] instrShift,
  input wire bst_pkg::bst_drive_t shiftDrive,
  input wire logic dataOutNext,
  input wire logic dataOutEnNext,
  output logic [bst_pkg::BST_INS_WIDTH-1:0] instr,
  output logic extestFlag,
  output logic boundarySel,
  output bst_pkg::bst_drive_t updLatch,
  output logic scanDataOut,
  output logic scanDataOutEn
);

  typedef struct packed {
    logic [bst_pkg::BST_INS_WIDTH-1:0] instr;
    logic extest;
    logic boundary;
    bst_pkg::bst_drive_t upd;
    logic dataOut;
    logic dataOutEn;
  } bst_neg_t;

  bst_neg_t n_reg;
  bst_neg_t n_next;
  logic [bst_pkg::BST_INS_WIDTH-1:0] instrNew;

  always_comb begin
    n_next = n_reg;
    instrNew = n_reg.instr;
    if (scanRst || tapState == bst_pkg::BST_TLR) begin
      instrNew = bst_pkg::BST_INS_RESET;
    end else if (tapState == bst_pkg::BST_UPD_INS) begin
      instrNew = instrShift; // [R15]
    end
    n_next.instr = instrNew; // [R1]
    n_next.extest = (instrNew == bst_pkg::BST_OP_EXTEST); // [R5]
    n_next.boundary = (instrNew == bst_pkg::BST_OP_EXTEST) ||
                      (instrNew == bst_pkg::BST_OP_SAMPLE); // [R6] [R7]
    if (tapState == bst_pkg::BST_UPD_DR && n_reg.boundary) begin
      n_next.upd = shiftDrive; // [R10] [R12] [R14] [R17]
    end
    n_next.dataOut = dataOutNext;
    n_next.dataOutEn = dataOutEnNext;
    if (scanRst) begin
      n_next.upd = '0;
      n_next.dataOut = 1'b0;
      n_next.dataOutEn = 1'b0;
    end
  end

  always_ff @(negedge scanClk) begin
    n_reg <= n_next;
  end

  assign instr = n_reg.instr;
  assign extestFlag = n_reg.extest;
  assign boundarySel = n_reg.boundary;
  assign updLatch = n_reg.upd;
  assign scanDataOut = n_reg.dataOut;
  assign scanDataOutEn = n_reg.dataOutEn;

endmodule

`default_nettype wire

// >>> rtl/bst_tap.sv
// How it works
// [R1] Four-bit instruction shifter with parallel current latch
// [R2] Shifter msb from data in, lsb out
// [R3] Capture of instruction loads fixed 1001 pattern
// [R4] Instruction shifter advances each rising shift edge
// [R5] Code 0000 selects extest through boundary chain
// [R6] Code 0100 selects sample/preload through boundary chain
// [R7] All other codes, ones included, mean bypass
// [R8] Bypass puts one stage between data pins
// [R9] Sample captures all input pins on rising edge
// [R10] Preload latches output cells on falling edge only
// [R11] Extest captures inputs exactly like sample does
// [R12] Extest latches on falling edge, drives output pins
// [R13] Enable cell captures received enable pin value
// [R14] Enable latch steers video drivers only in extest
// [R15] Update of instruction latches on falling edge
// [R16] Selected data register shifts toward data out
// [R17] Output cells own latches; input cells drive nothing
// [R18] Sixteen-state controller steered by mode select
`default_nettype none

module bst_tap (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic scanClk,
  input wire logic scanModeSel,
  input wire logic scanDataIn,
  output logic scanDataOut,
  output logic scanDataOutEn,
  input wire logic [bst_pkg::BST_IN_CELLS-1:0] pinInputs,
  input wire logic videoOutputEnable,
  input wire logic [bst_pkg::BST_VIDEO_WIDTH-1:0] coreVideoData,
  output logic [bst_pkg::BST_VIDEO_WIDTH-1:0] videoOutputBus,
  output logic videoOutputBusEn,
  output logic extestActive
);

  // Reference-clock side: reset hold and extest status back to the core
  typedef struct packed {
    logic rstHold;
    logic extSync1;
    logic extSync2;
  } bst_ref_t;

  // Scan-clock side, rising edge
  typedef struct packed {
    bst_pkg::bst_tap_state_t tap;
    logic [bst_pkg::BST_INS_WIDTH-1:0] instrShift;
    logic bypassStage;
    bst_pkg::bst_cells_t chain;
    bst_pkg::bst_cells_t pinSync1;
    bst_pkg::bst_cells_t pinSync2;
    logic rstSync1;
    logic rstSync2;
  } bst_scan_t;

  bst_ref_t r_reg;
  bst_ref_t r_next;
  bst_scan_t s_reg;
  bst_scan_t s_next;

  logic scanRst;
  logic [bst_pkg::BST_INS_WIDTH-1:0] instr;
  logic extestFlag;
  logic boundarySel;
  bst_pkg::bst_drive_t updLatch;
  bst_pkg::bst_drive_t shiftDrive;
  bst_pkg::bst_cells_t pinSample;
  logic [bst_pkg::BST_CHAIN_LEN-1:0] chainBits;
  logic dataOutNext;
  logic dataOutEnNext;

  assign scanRst = s_reg.rstSync2;

  // Reference-clock domain
  always_comb begin
    r_next = r_reg;
    r_next.rstHold = reset;
    // Extest flag is a registered level, safe to synchronise
    r_next.extSync1 = extestFlag;
    r_next.extSync2 = r_reg.extSync1;
    if (reset) begin
      r_next.extSync1 = 1'b0;
      r_next.extSync2 = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    r_reg <= r_next;
  end

  assign extestActive = r_reg.extSync2;

  // Everything captured comes from other clocks, so it is
  // resynchronised; a capture sees pins two scan edges old.
  always_comb begin
    pinSample.inputs = pinInputs; // [R9] [R11]
    pinSample.video = coreVideoData;
    pinSample.videoEn = videoOutputEnable; // [R13]
  end

  assign chainBits = s_reg.chain;

  // One chain cell per bit; each takes its neighbour nearer the input
  logic [bst_pkg::BST_CHAIN_LEN-1:0] shiftBits;
  for (genvar i = 0; i < bst_pkg::BST_CHAIN_LEN; i++) begin : g_cell
    if (i == 0) begin : g_first
      assign shiftBits[i] = scanDataIn;
    end else begin : g_rest
      assign shiftBits[i] = chainBits[i-1];
    end
  end

  // Controller next state
  function automatic bst_pkg::bst_tap_state_t tapStep(
    input bst_pkg::bst_tap_state_t cur,
    input logic ms
  );
    bst_pkg::bst_tap_state_t nxt;
    nxt = bst_pkg::BST_TLR;
    case (cur)
      bst_pkg::BST_TLR: begin
        if (ms) begin
          nxt = bst_pkg::BST_TLR;
        end else begin
          nxt = bst_pkg::BST_IDLE;
        end
      end
      bst_pkg::BST_IDLE: begin
        if (ms) begin
          nxt = bst_pkg::BST_SEL_DR;
        end else begin
          nxt = bst_pkg::BST_IDLE;
        end
      end
      bst_pkg::BST_SEL_DR: begin
        if (ms) begin
          nxt = bst_pkg::BST_SEL_INS;
        end else begin
          nxt = bst_pkg::BST_CAP_DR;
        end
      end
      bst_pkg::BST_CAP_DR: begin
        if (ms) begin
          nxt = bst_pkg::BST_EX1_DR;
        end else begin
          nxt = bst_pkg::BST_SHF_DR;
        end
      end
      bst_pkg::BST_SHF_DR: begin
        if (ms) begin
          nxt = bst_pkg::BST_EX1_DR;
        end else begin
          nxt = bst_pkg::BST_SHF_DR;
        end
      end
      bst_pkg::BST_EX1_DR: begin
        if (ms) begin
          nxt = bst_pkg::BST_UPD_DR;
        end else begin
          nxt = bst_pkg::BST_PAU_DR;
        end
      end
      bst_pkg::BST_PAU_DR: begin
        if (ms) begin
          nxt = bst_pkg::BST_EX2_DR;
        end else begin
          nxt = bst_pkg::BST_PAU_DR;
        end
      end
      bst_pkg::BST_EX2_DR: begin
        if (ms) begin
          nxt = bst_pkg::BST_UPD_DR;
        end else begin
          nxt = bst_pkg::BST_SHF_DR;
        end
      end
      bst_pkg::BST_UPD_DR: begin
        if (ms) begin
          nxt = bst_pkg::BST_SEL_DR;
        end else begin
          nxt = bst_pkg::BST_IDLE;
        end
      end
      bst_pkg::BST_SEL_INS: begin
        if (ms) begin
          nxt = bst_pkg::BST_TLR;
        end else begin
          nxt = bst_pkg::BST_CAP_INS;
        end
      end
      bst_pkg::BST_CAP_INS: begin
        if (ms) begin
          nxt = bst_pkg::BST_EX1_INS;
        end else begin
          nxt = bst_pkg::BST_SHF_INS;
        end
      end
      bst_pkg::BST_SHF_INS: begin
        if (ms) begin
          nxt = bst_pkg::BST_EX1_INS;
        end else begin
          nxt = bst_pkg::BST_SHF_INS;
        end
      end
      bst_pkg::BST_EX1_INS: begin
        if (ms) begin
          nxt = bst_pkg::BST_UPD_INS;
        end else begin
          nxt = bst_pkg::BST_PAU_INS;
        end
      end
      bst_pkg::BST_PAU_INS: begin
        if (ms) begin
          nxt = bst_pkg::BST_EX2_INS;
        end else begin
          nxt = bst_pkg::BST_PAU_INS;
        end
      end
      bst_pkg::BST_EX2_INS: begin
        if (ms) begin
          nxt = bst_pkg::BST_UPD_INS;
        end else begin
          nxt = bst_pkg::BST_SHF_INS;
        end
      end
      bst_pkg::BST_UPD_INS: begin
        if (ms) begin
          nxt = bst_pkg::BST_SEL_DR;
        end else begin
          nxt = bst_pkg::BST_IDLE;
        end
      end
      default: begin
        nxt = bst_pkg::BST_TLR;
      end
    endcase
    return nxt;
  endfunction

  // Scan-clock domain, rising edge
  always_comb begin
    s_next = s_reg;
    s_next.rstSync1 = r_reg.rstHold;
    s_next.rstSync2 = s_reg.rstSync1;
    s_next.pinSync1 = pinSample;
    s_next.pinSync2 = s_reg.pinSync1;
    s_next.tap = tapStep(s_reg.tap, scanModeSel); // [R18]
    case (s_reg.tap)
      bst_pkg::BST_CAP_INS: begin
        s_next.instrShift = bst_pkg::BST_INS_CAPTURE; // [R3]
      end
      bst_pkg::BST_SHF_INS: begin
        s_next.instrShift = {scanDataIn,
                             s_reg.instrShift[bst_pkg::BST_INS_WIDTH-1:1]};
      end
      bst_pkg::BST_CAP_DR: begin
        if (boundarySel) begin
          s_next.chain = s_reg.pinSync2; // [R9] [R11] [R13]
        end else begin
          s_next.bypassStage = bst_pkg::BST_BYPASS_CAPTURE;
        end
      end
      bst_pkg::BST_SHF_DR: begin
        if (boundarySel) begin
          s_next.chain = bst_pkg::bst_cells_t'(shiftBits); // [R16]
        end else begin
          s_next.bypassStage = scanDataIn; // [R8] [R16]
        end
      end
      default: begin
        s_next.tap = s_next.tap;
      end
    endcase
    if (s_reg.tap == bst_pkg::BST_SHF_INS) begin
      // Msb takes new data; values arrive lsb first
      s_next.instrShift[bst_pkg::BST_INS_WIDTH-1] = scanDataIn; // [R2] [R4]
    end
    if (scanRst) begin
      s_next.tap = bst_pkg::BST_TLR;
      s_next.instrShift = '0;
      s_next.bypassStage = 1'b0;
      s_next.chain = '0;
    end
  end

  always_ff @(posedge scanClk) begin
    s_reg <= s_next;
  end

  // Only the output cells feed update latches
  always_comb begin
    shiftDrive.videoEn = s_reg.chain.videoEn;
    shiftDrive.video = s_reg.chain.video; // [R17]
  end

  // Serial output mux, retimed on the falling edge
  always_comb begin
    dataOutNext = 1'b0;
    dataOutEnNext = 1'b0;
    case (s_reg.tap)
      bst_pkg::BST_SHF_INS: begin
        dataOutNext = s_reg.instrShift[0]; // [R2]
        dataOutEnNext = 1'b1;
      end
      bst_pkg::BST_SHF_DR: begin
        dataOutEnNext = 1'b1;
        if (boundarySel) begin
          dataOutNext = chainBits[bst_pkg::BST_CHAIN_LEN-1]; // [R5] [R6]
        end else begin
          dataOutNext = s_reg.bypassStage; // [R7] [R8]
        end
      end
      default: begin
        dataOutEnNext = 1'b0;
      end
    endcase
  end

  bst_update_stage u_update (
    .scanClk(scanClk),
    .scanRst(scanRst),
    .tapState(s_reg.tap),
    .instrShift(s_reg.instrShift),
    .shiftDrive(shiftDrive),
    .dataOutNext(dataOutNext),
    .dataOutEnNext(dataOutEnNext),
    .instr(instr),
    .extestFlag(extestFlag),
    .boundarySel(boundarySel),
    .updLatch(updLatch),
    .scanDataOut(scanDataOut),
    .scanDataOutEn(scanDataOutEn)
  );

  // Pins follow the core except under extest; the instruction itself
  // is never used here, only its registered decode, to avoid glitches.
  always_comb begin
    if (extestFlag) begin
      videoOutputBus = updLatch.video; // [R12]
      videoOutputBusEn = updLatch.videoEn; // [R14]
    end else begin
      videoOutputBus = coreVideoData; // [R10]
      videoOutputBusEn = videoOutputEnable;
    end
  end

endmodule

`default_nettype wire

// >>> bench/bst_tap_checker.sv
`default_nettype none

module bst_tap_checker (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic scanClk,
  input wire logic scanModeSel,
  input wire logic scanDataIn,
  input wire logic scanDataOut,
  input wire logic scanDataOutEn,
  input wire logic [bst_pkg::BST_IN_CELLS-1:0] pinInputs,
  input wire logic videoOutputEnable,
  input wire logic [bst_pkg::BST_VIDEO_WIDTH-1:0] coreVideoData,
  input wire logic [bst_pkg::BST_VIDEO_WIDTH-1:0] videoOutputBus,
  input wire logic videoOutputBusEn,
  input wire logic extestActive
);
  // Next-state nibbles per state, for mode select low and high
  localparam logic [63:0] NEXT_LO = 64'h1bddbba146644311;
  localparam logic [63:0] NEXT_HI = 64'h2fefcc0287855920;
  logic [3:0] stReg, irReg, insReg;
  logic byp, shifting;
  assign byp = insReg != bst_pkg::BST_OP_EXTEST
    && insReg != bst_pkg::BST_OP_SAMPLE;
  assign shifting = stReg == bst_pkg::BST_SHF_DR
    || stReg == bst_pkg::BST_SHF_INS;
  always_ff @(posedge scanClk) begin
    stReg <= reset ? 4'h0 : scanModeSel ? NEXT_HI[{stReg, 2'b00} +: 4]
      : NEXT_LO[{stReg, 2'b00} +: 4];
    irReg <= stReg == bst_pkg::BST_CAP_INS ? bst_pkg::BST_INS_CAPTURE
      : stReg == bst_pkg::BST_SHF_INS ? {scanDataIn, irReg[3:1]} : irReg;
  end
  always_ff @(negedge scanClk) begin
    insReg <= (reset || stReg == bst_pkg::BST_TLR) ? bst_pkg::BST_INS_RESET
      : stReg == bst_pkg::BST_UPD_INS ? irReg : insReg;
  end
  shift_enable_a:
    assert property (@(posedge scanClk) disable iff (reset)
      scanDataOutEn == shifting) else $error("scan enable wrong");
  ir_capture_a:
    assert property (@(posedge scanClk) disable iff (reset)
      stReg == bst_pkg::BST_CAP_INS && !scanModeSel |=> scanDataOut ##1
      (!scanDataOut || stReg != bst_pkg::BST_SHF_INS))
      else $error("capture pattern wrong");
  ir_shift_a:
    assert property (@(posedge scanClk) disable iff (reset)
      (stReg == bst_pkg::BST_SHF_INS) [*4] ##0 !scanModeSel |=>
      scanDataOut == $past(scanDataIn, 4)) else $error("ir path wrong");
  bypass_path_a:
    assert property (@(posedge scanClk) disable iff (reset)
      stReg == bst_pkg::BST_SHF_DR && byp && !scanModeSel |=>
      scanDataOut == $past(scanDataIn)) else $error("bypass path wrong");
  bypass_cap_a:
    assert property (@(posedge scanClk) disable iff (reset)
      stReg == bst_pkg::BST_CAP_DR && byp && !scanModeSel |=> !scanDataOut)
      else $error("bypass capture wrong");
  extest_track_a:
    assert property (@(posedge scanClk) disable iff (reset)
      stReg == bst_pkg::BST_UPD_INS |-> ##2 extestActive == (irReg == 4'h0))
      else $error("extest flag wrong");
  ext_clear_a:
    assert property (@(posedge ref_clk) disable iff (reset)
      $fell(reset) |-> !extestActive) else $error("extest after reset");
  core_pass_a:
    assert property (@(posedge ref_clk) disable iff (reset)
      !extestActive [*4] |-> $past(videoOutputBus, 3)
      == $past(coreVideoData, 3) && $past(videoOutputBusEn, 3)
      == $past(videoOutputEnable, 3)) else $error("video bus not core");
  cover property (@(negedge scanClk) stReg == bst_pkg::BST_UPD_DR
    && insReg == bst_pkg::BST_OP_EXTEST);
  cover property (@(negedge scanClk) stReg == bst_pkg::BST_UPD_DR
    && insReg == bst_pkg::BST_OP_SAMPLE);
  cover property (@(posedge scanClk) shifting && byp);
endmodule

bind bst_tap bst_tap_checker u_chk (.ref_clk, .reset, .scanClk,
  .scanModeSel, .scanDataIn, .scanDataOut, .scanDataOutEn, .pinInputs,
  .videoOutputEnable, .coreVideoData, .videoOutputBus, .videoOutputBusEn,
  .extestActive);

`default_nettype wire

// >>> bench/bst_scan_host.sv
`default_nettype none

// Board test controller; its clock only runs inside its own sequences
module bst_scan_host (
  output logic scanClk,
  output logic scanModeSel,
  output logic scanDataIn,
  input wire logic scanDataOut
);
  timeunit 1ns;
  timeprecision 1ps;
  int gap = 0;
  initial begin
    scanClk = 1'b0;
    scanModeSel = 1'b1;
    scanDataIn = 1'b1;
  end
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    scanModeSel = tms;
    scanDataIn = tdi;
    #(8 + gap);
    tdo = scanDataOut;
    scanClk = 1'b1;
    #16;
    scanClk = 1'b0;
    #8;
  endtask
  task automatic tlr();
    logic o;
    repeat (5) step(1'b1, 1'b1, o);
  endtask
  // Data line idles high, as the board pull-up leaves it
  task automatic scan(input logic toIr, input int n, input logic [24:0] d,
      output logic [24:0] q);
    logic o;
    q = '0;
    step(1'b0, 1'b1, o);
    step(1'b1, 1'b1, o);
    if (toIr) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    step(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, d[i], o);
      q[i] = o;
    end
    step(1'b1, 1'b1, o);
    repeat (3) step(1'b0, 1'b1, o);
  endtask
endmodule

`default_nettype wire

// >>> bench/bst_tap_test.sv
`default_nettype none

module bst_tap_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, reset, videoOutputEnable, videoOutputBusEn, extestActive;
  logic scanClk, scanModeSel, scanDataIn, scanDataOut, scanDataOutEn;
  logic [bst_pkg::BST_IN_CELLS-1:0] pinInputs;
  logic [bst_pkg::BST_VIDEO_WIDTH-1:0] coreVideoData, videoOutputBus;
  int n_fail = 0;
  int compares = 0;
  bst_tap i_dut (.ref_clk, .reset, .scanClk, .scanModeSel, .scanDataIn,
    .scanDataOut, .scanDataOutEn, .pinInputs, .videoOutputEnable,
    .coreVideoData, .videoOutputBus, .videoOutputBusEn, .extestActive);
  bst_scan_host i_host (.scanClk, .scanModeSel, .scanDataIn, .scanDataOut);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [24:0] act, input logic [24:0] exp);
    compares++;
    if (act !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask
  task automatic complete_run();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic test_reset();
    chk({extestActive, scanDataOutEn, videoOutputBusEn, videoOutputBus},
      {2'b00, videoOutputEnable, coreVideoData});
  endtask
  // Eight-bit instruction scan also pushes the captured pattern out
  task automatic test_code(input logic [3:0] code);
    logic [24:0] d, q, cells, load;
    @(posedge ref_clk);
    #1;
    pinInputs = {code, ~code};
    coreVideoData = {~code, code, 8'h3c};
    videoOutputEnable = code[1];
    i_host.gap = code[0] ? 40 : 0;
    d = {17'h0, code, ~code};
    i_host.scan(1'b1, 8, d, q);
    chk(q[7:0], {~code, 4'h9});
    chk(extestActive, code == bst_pkg::BST_OP_EXTEST);
    cells = {videoOutputEnable, coreVideoData, pinInputs};
    load = {<<{cells}};
    d = {code, 21'h1a5f36};
    i_host.scan(1'b0, 25, d, q);
    if (code == bst_pkg::BST_OP_EXTEST || code == bst_pkg::BST_OP_SAMPLE)
      chk(q, load);
    else
      chk(q, {d[23:0], 1'b0});
    cells = {<<{d}};
    if (code == bst_pkg::BST_OP_EXTEST)
      chk({videoOutputBusEn, videoOutputBus}, cells[24:8]);
    else
      chk({videoOutputBusEn, videoOutputBus},
        {videoOutputEnable, coreVideoData});
  endtask
  // Preload alone leaves the pins on the core until extest comes in
  task automatic test_preload();
    logic [24:0] q, d, cells;
    i_host.gap = 0;
    d = 25'h0a5c3e;
    i_host.scan(1'b1, 4, 25'h4, q);
    i_host.scan(1'b0, 25, d, q);
    chk({videoOutputBusEn, videoOutputBus},
      {videoOutputEnable, coreVideoData});
    i_host.scan(1'b1, 4, 25'h0, q);
    cells = {<<{d}};
    chk({videoOutputBusEn, videoOutputBus}, cells[24:8]);
  endtask
  task automatic test_tlr();
    logic [24:0] q;
    i_host.scan(1'b1, 4, 25'h0, q);
    chk(extestActive, 1'b1);
    i_host.tlr();
    repeat (4) @(posedge ref_clk);
    #1;
    chk({extestActive, videoOutputBusEn, videoOutputBus},
      {1'b0, videoOutputEnable, coreVideoData});
  endtask
  initial begin
    reset = 1'b1;
    pinInputs = 8'h00;
    videoOutputEnable = 1'b1;
    coreVideoData = 16'h0000;
    repeat (2) @(posedge ref_clk);
    i_host.tlr();
    @(posedge ref_clk);
    #1;
    reset = 1'b0;
    i_host.tlr();
    test_reset();
    for (int c = 0; c < 16; c++) begin
      test_code(4'(c));
    end
    test_preload();
    test_tlr();
    complete_run();
  end
  initial begin
    #200000;
    n_fail++;
    complete_run();
  end
endmodule

`default_nettype wire
